/* File: charger_info_consts.vh */
`ifndef CHARGER_INFO_CONSTS_VH
`define CHARGER_INFO_CONSTS_VH
// Register offsets
`define INFO_ONE_ADDR 8'h3A
`define INFO_TWO_ADDR 8'h4D
// First register field positions
`define ONE_DIODE_BIT 0
`define ONE_REVTURBO_BIT 1
`define ONE_BYPASS_PUMP_BIT 2
`define ONE_INPUT_PUMP_BIT 3
`define ONE_TRICKLE_BIT 4
`define ONE_SENSE_CMP_BIT 5
`define ONE_BATTERY_PUMP_BIT 6
`define ONE_LOWSYS_TRIP_BIT 10
`define ONE_DISCHARGE_TRIP_BIT 11
`define ONE_ADAPTER_TRIP_BIT 12
`define ONE_LOOP_LSB 13
`define ONE_LOOP_MSB 14
`define ONE_REF_ACTIVE_BIT 15
// Second register field positions
`define TWO_CONFIG_LSB 0
`define TWO_CONFIG_MSB 4
`define TWO_STAGE_LSB 5
`define TWO_STAGE_MSB 7
`define TWO_STATE_LSB 8
`define TWO_STATE_MSB 11
`define TWO_BATTERY_ABSENT_BIT 12
`define TWO_COMPARATOR_BIT 13
`define TWO_ADAPTER_PRESENT_BIT 14
// State codes
`define STATE_RESET 4'h0
`define STATE_AUTO_CHARGE 4'h2
`define STATE_BATTERY_ONLY 4'h4
`define STATE_HOST_CHARGE 4'h6
`define STATE_FAULT 4'h7
`define STATE_REVERSE 4'h9
`define STATE_READY 4'hA
`define STATE_SWITCHING 4'hC
`define STATE_STARTUP 4'h1
`define STATE_STARTUP_LATE 4'h8
// Reset value of read data
`define READ_DATA_RESET 16'h0000
`endif

/* File: pin_sync.v */
`timescale 1ns/1ns
module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    // Two flip-flops per bit, each bit owns its stages; only the second stage is read
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gSync
            reg stageOne_reg;
            reg stageTwo_reg;
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    stageOne_reg <= 1'b0;
                    stageTwo_reg <= 1'b0;
                end else begin
                    stageOne_reg <= asyncIn[i];
                    stageTwo_reg <= stageOne_reg;
                end
            end
            assign syncOut[i] = stageTwo_reg;
        end
    endgenerate
endmodule

/* File: state_code_encoder.v */
`timescale 1ns/1ns
`include "charger_info_consts.vh"
module state_code_encoder (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Synchronised condition levels
    input wire startupBusy,
    input wire faultActive,
    input wire reverseActive,
    input wire autoCharging,
    input wire hostCharging,
    input wire switchingForward,
    input wire batteryOnly,
    input wire startupCode,
    // Encoded state
    output reg [3:0] stateCode_reg
);
    reg [3:0] stateCode_next;

    // Priority pick of the reported state code
    always @* begin
        stateCode_next = `STATE_READY;
        if (startupBusy) begin
            stateCode_next = `STATE_STARTUP;
        end else if (faultActive) begin
            stateCode_next = `STATE_FAULT;
        end else if (reverseActive) begin
            stateCode_next = `STATE_REVERSE;
        end else if (autoCharging) begin
            stateCode_next = `STATE_AUTO_CHARGE;
        end else if (hostCharging) begin
            stateCode_next = `STATE_HOST_CHARGE;
        end else if (switchingForward) begin
            stateCode_next = `STATE_SWITCHING;
        end else if (batteryOnly) begin
            stateCode_next = `STATE_BATTERY_ONLY;
        end
        if (startupBusy && startupCode) begin
            stateCode_next = `STATE_STARTUP_LATE;
        end
    end

    // State register, zero in reset
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateCode_reg <= `STATE_RESET;
        end else begin
            stateCode_reg <= stateCode_next;
        end
    end
endmodule

/* File: charger_info_status_regs.v */
`timescale 1ns/1ns
`include "charger_info_consts.vh"
//
// Behaviour
// - Two readable info registers at 0x3A, 0x4D
// - First bit 0 shows diode mode
// - First bit 1 shows reverse turbo mode
// - Bits 2,3,6 show gate pumps good
// - Pump good bits may toggle from leakage
// - First bit 4 shows trickle charging
// - First bit 5 compares adapter and system sense
// - Bits 10-12 show throttle trips
// - Bits 14:13 encode active regulation loop
// - Bit 15 shows reference active, else low power
// - Second bits 4:0 show config resistor readout
// - Second bits 7:5 encode power stage mode
// - State field zero in reset, startup codes
// - State 0010 auto charge, 0100 battery only
// - State 0110 host charge, 0111 fault
// - State 1001 reverse or supplemental mode
// - State 1010 biased but not switching
// - State 1100 forward switching regulation
// - Second bit 12 shows battery absent pin
// - Second bit 13 shows debounced comparator
// - Second bit 14 shows adapter present pin
//
module charger_info_status_regs (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Register read port
    input wire readStrobe,
    input wire writeStrobe,
    input wire [7:0] regAddr,
    input wire [15:0] writeData,
    output reg [15:0] readData_reg,
    output reg readValid_reg,
    output reg addrHit_reg,
    // Operating mode levels from the analog core
    input wire diodeMode,
    input wire reverseTurbo,
    input wire tricklCharge,
    input wire [1:0] activeLoop,
    input wire refActive,
    input wire [2:0] stageMode,
    // Charge pump health
    input wire bypass_gate_pump,
    input wire input_gate_pump,
    input wire battery_gate_pump,
    // Comparators and trips
    input wire senseCompare,
    input wire lowSystemTrip,
    input wire discharge_throttle_trip,
    input wire adapter_current_throttle_trip,
    input wire reverse_current_throttle_trip,
    input wire comparatorDebounced,
    // Pins
    input wire battery_absent_pin,
    input wire adapter_present_pin,
    // Configuration resistor readout
    input wire [4:0] configReadout,
    // State machine conditions
    input wire startupBusy,
    input wire startupCode,
    input wire faultActive,
    input wire reverseActive,
    input wire autoCharging,
    input wire hostCharging,
    input wire switchingForward,
    input wire batteryOnly
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    localparam SYNC_W = 33;
    wire [SYNC_W-1:0] asyncBus;
    wire [SYNC_W-1:0] syncBus;
    wire [3:0] stateCode;

    // Gather every asynchronous level into one bus
    assign asyncBus = {diodeMode, reverseTurbo, tricklCharge, activeLoop, refActive, stageMode,
                       bypass_gate_pump, input_gate_pump, battery_gate_pump,
                       senseCompare, lowSystemTrip, discharge_throttle_trip,
                       adapter_current_throttle_trip, reverse_current_throttle_trip,
                       comparatorDebounced, battery_absent_pin, adapter_present_pin, configReadout,
                       startupBusy, startupCode, faultActive, reverseActive, autoCharging,
                       hostCharging, switchingForward, batteryOnly};

    pin_sync #(
        .WIDTH(SYNC_W)
    ) uSync (
        .mclk(mclk),
        .rst(rst),
        .asyncIn(asyncBus),
        .syncOut(syncBus)
    );

    // Unpack synchronised levels
    wire sDiode = syncBus[32];
    wire sRevTurbo = syncBus[31];
    wire sTrickle = syncBus[30];
    wire [1:0] sLoop = syncBus[29:28];
    wire sRef = syncBus[27];
    wire [2:0] sStage = syncBus[26:24];
    wire sBypassPump = syncBus[23];
    wire sInputPump = syncBus[22];
    wire sBatteryPump = syncBus[21];
    wire sSense = syncBus[20];
    wire sLowSys = syncBus[19];
    wire sDischarge = syncBus[18];
    wire sAdapterTrip = syncBus[17];
    wire sReverseTrip = syncBus[16];
    wire sComparator = syncBus[15];
    wire sBatteryAbsent = syncBus[14];
    wire sAdapterPresent = syncBus[13];
    wire [4:0] sConfig = syncBus[12:8];

    // ------------------------------------------------------------
    // State code
    // ------------------------------------------------------------
    state_code_encoder uState (
        .mclk(mclk),
        .rst(rst),
        .startupBusy(syncBus[7]),
        .startupCode(syncBus[6]),
        .faultActive(syncBus[5]),
        .reverseActive(syncBus[4]),
        .autoCharging(syncBus[3]),
        .hostCharging(syncBus[2]),
        .switchingForward(syncBus[1]),
        .batteryOnly(syncBus[0]),
        .stateCode_reg(stateCode)
    );

    // ------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------
    reg [15:0] infoOne;
    reg [15:0] infoTwo;

    // First information register, pumps shown raw as they may toggle
    always @* begin
        infoOne = 16'h0000;
        infoOne[`ONE_DIODE_BIT] = sDiode;
        infoOne[`ONE_REVTURBO_BIT] = sRevTurbo;
        infoOne[`ONE_BYPASS_PUMP_BIT] = sBypassPump;
        infoOne[`ONE_INPUT_PUMP_BIT] = sInputPump;
        infoOne[`ONE_BATTERY_PUMP_BIT] = sBatteryPump;
        infoOne[`ONE_TRICKLE_BIT] = sTrickle;
        infoOne[`ONE_SENSE_CMP_BIT] = sSense;
        infoOne[`ONE_LOWSYS_TRIP_BIT] = sLowSys;
        infoOne[`ONE_DISCHARGE_TRIP_BIT] = sDischarge;
        infoOne[`ONE_ADAPTER_TRIP_BIT] = sAdapterTrip | sReverseTrip;
        infoOne[`ONE_LOOP_MSB:`ONE_LOOP_LSB] = sLoop;
        infoOne[`ONE_REF_ACTIVE_BIT] = sRef;
    end

    // Second information register
    always @* begin
        infoTwo = 16'h0000;
        infoTwo[`TWO_CONFIG_MSB:`TWO_CONFIG_LSB] = sConfig;
        infoTwo[`TWO_STAGE_MSB:`TWO_STAGE_LSB] = sStage;
        infoTwo[`TWO_STATE_MSB:`TWO_STATE_LSB] = stateCode;
        infoTwo[`TWO_BATTERY_ABSENT_BIT] = sBatteryAbsent;
        infoTwo[`TWO_COMPARATOR_BIT] = sComparator;
        infoTwo[`TWO_ADAPTER_PRESENT_BIT] = sAdapterPresent;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    reg [15:0] readData_next;
    reg addrHit_next;

    // Address decode; other addresses and writes return zero
    always @* begin
        readData_next = `READ_DATA_RESET;
        addrHit_next = 1'b0;
        if (readStrobe && !writeStrobe) begin
            case (regAddr)
                `INFO_ONE_ADDR: begin
                    readData_next = infoOne;
                    addrHit_next = 1'b1;
                end
                `INFO_TWO_ADDR: begin
                    readData_next = infoTwo;
                    addrHit_next = 1'b1;
                end
                default: begin
                    readData_next = `READ_DATA_RESET;
                    addrHit_next = 1'b0;
                end
            endcase
        end
    end

    // Output registers, one-cycle answer to a read
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            readData_reg <= `READ_DATA_RESET;
            readValid_reg <= 1'b0;
            addrHit_reg <= 1'b0;
        end else begin
            readData_reg <= readData_next;
            readValid_reg <= readStrobe & ~writeStrobe;
            addrHit_reg <= addrHit_next;
        end
    end

    // Write data is accepted on the port and discarded
    wire unusedWrite = |writeData;
endmodule

/* File: info_regs_properties.sv */
`timescale 1ns/1ns
module info_regs_properties (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Read port
    input wire readStrobe,
    input wire writeStrobe,
    input wire [7:0] regAddr,
    input wire [15:0] readData_reg,
    input wire readValid_reg,
    input wire addrHit_reg,
    // Watched levels
    input wire diodeMode,
    input wire faultActive,
    input wire startupBusy
);
    reg [2:0] upCnt_reg;
    wire rd = readStrobe && !writeStrobe;
    wire mapped = regAddr == 8'h3A || regAddr == 8'h4D;
    // Cycles since reset, so sync stages are filled
    always @(posedge mclk or posedge rst) begin
        if (rst) upCnt_reg <= 3'h0;
        else if (upCnt_reg != 3'h7) upCnt_reg <= upCnt_reg + 3'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence rdOne; rd && regAddr == 8'h3A; endsequence
    sequence rdTwo; rd && regAddr == 8'h4D; endsequence
    a_read_answered: assert property (rd |=> readValid_reg) else $error("read not answered");
    a_no_stray: assert property (!rd |=>
        !readValid_reg && readData_reg == 16'h0000) else $error("stray answer");
    a_hit_mapped: assert property (rd |=> addrHit_reg == $past(mapped)) else $error("hit flag wrong");
    a_miss_zero: assert property (rd && !mapped |=> readData_reg == 16'h0000) else $error("unmapped data");
    a_unused_one: assert property (rdOne |=> readData_reg[9:7] == 3'h0) else $error("unused bits set");
    a_unused_two: assert property (rdTwo |=> !readData_reg[15]) else $error("top bit set");
    a_diode_live: assert property ((upCnt_reg == 3'h7 && $stable(diodeMode)) [*4] ##0 rdOne
        |=> readData_reg[0] == $past(diodeMode)) else $error("diode bit wrong");
    a_fault_code: assert property ((upCnt_reg == 3'h7 && faultActive && !startupBusy) [*5] ##0 rdTwo
        |=> readData_reg[11:8] == 4'h7) else $error("fault code wrong");
endmodule
bind charger_info_status_regs info_regs_properties chk (.mclk(mclk), .rst(rst), .readStrobe(readStrobe),
    .writeStrobe(writeStrobe), .regAddr(regAddr), .readData_reg(readData_reg), .readValid_reg(readValid_reg),
    .addrHit_reg(addrHit_reg), .diodeMode(diodeMode), .faultActive(faultActive), .startupBusy(startupBusy));

/* File: analog_core_model.sv */
`timescale 1ns/1ns
module analog_core_model (
    // Clock
    input wire mclk,
    // Requested and presented levels
    input wire [35:0] want,
    output reg [35:0] levels
);
    // Levels settle a little after the edge, like slow analog outputs
    initial levels = 36'h0;
    always @(posedge mclk) begin
        levels <= #2 want;
    end
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg readStrobe = 1'b0;
    reg writeStrobe = 1'b0;
    reg [7:0] regAddr = 8'h00;
    reg [35:0] want = 36'h0;
    wire [35:0] lv;
    wire [15:0] readData_reg;
    wire readValid_reg;
    wire addrHit_reg;
    integer fails = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer i;
    reg [15:0] one;
    reg [7:0] cfg;
    // State table entries: condition levels, expected code
    localparam [143:0] TBL = {8'h00, 4'hA, 8'h01, 4'h4, 8'h02, 4'hC, 8'h04, 4'h6, 8'h08, 4'h2, 8'h10, 4'h9,
        8'h20, 4'h7, 8'h80, 4'h1, 8'hC0, 4'h8, 8'h3F, 4'h7, 8'h07, 4'h6, 8'h0F, 4'h2};
    always #4 mclk = ~mclk;
    analog_core_model core (.mclk(mclk), .want(want), .levels(lv));
    charger_info_status_regs DUT (.mclk(mclk), .rst(rst), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
        .regAddr(regAddr), .writeData(16'hFFFF), .readData_reg(readData_reg), .readValid_reg(readValid_reg),
        .addrHit_reg(addrHit_reg), .diodeMode(lv[0]), .reverseTurbo(lv[1]), .bypass_gate_pump(lv[2]),
        .input_gate_pump(lv[3]), .tricklCharge(lv[4]), .senseCompare(lv[5]), .battery_gate_pump(lv[6]),
        .lowSystemTrip(lv[10]), .discharge_throttle_trip(lv[11]), .adapter_current_throttle_trip(lv[12]),
        .activeLoop(lv[14:13]), .refActive(lv[15]), .configReadout(lv[20:16]), .stageMode(lv[23:21]),
        .battery_absent_pin(lv[24]), .comparatorDebounced(lv[25]), .adapter_present_pin(lv[26]),
        .reverse_current_throttle_trip(lv[27]), .batteryOnly(lv[28]), .switchingForward(lv[29]),
        .hostCharging(lv[30]), .autoCharging(lv[31]), .reverseActive(lv[32]), .faultActive(lv[33]),
        .startupCode(lv[34]), .startupBusy(lv[35]));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task cmp(input string name, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[ERR] %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // One access cycle; outputs stand in the following cycle
    task access(input rd, input wr, input [7:0] a);
        begin
            @(posedge mclk);
            #1 readStrobe = rd;
            writeStrobe = wr;
            regAddr = a;
            @(posedge mclk);
            #1 readStrobe = 1'b0;
            writeStrobe = 1'b0;
        end
    endtask
    task rdChk(input [7:0] a, input [15:0] exp);
        begin
            access(1'b1, 1'b0, a);
            cmp("data", exp, readData_reg);
            cmp("valid", 16'h0001, {15'h0, readValid_reg});
            cmp("hit", {15'h0, a == 8'h3A || a == 8'h4D}, {15'h0, addrHit_reg});
        end
    endtask
    // Present new levels and let them pass the sync stages
    task setLv(input [35:0] v);
        begin
            @(posedge mclk);
            #1 want = v;
            repeat (5) @(posedge mclk);
        end
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            conclude;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        cmp("rstdata", 16'h0000, readData_reg);
        for (i = 0; i < 8; i = i + 1) begin
            one = {i[0], i[1:0], 13'h1FFF >> i};
            cfg = {i[2:0], 5'h1F ^ i[4:0]};
            setLv({8'h00, i[0], i[2:0], cfg, one});
            one[12] = one[12] | i[0];
            rdChk(8'h3A, one & 16'hFC7F);
            rdChk(8'h4D, {1'b0, i[2:0], 4'hA, cfg});
        end
        for (i = 0; i < 12; i = i + 1) begin
            setLv({TBL[(11 - i) * 12 + 4 +: 8], 28'h0});
            rdChk(8'h4D, {4'h0, TBL[(11 - i) * 12 +: 4], 8'h00});
        end
        for (i = 0; i < 4; i = i + 1) rdChk(8'h3B + 8'h11 * i[7:0], 16'h0000);
        setLv(36'h1);
        access(1'b1, 1'b1, 8'h3A);
        cmp("wvalid", 16'h0000, {15'h0, readValid_reg});
        access(1'b0, 1'b1, 8'h3A);
        rdChk(8'h3A, 16'h0001);
        @(posedge mclk);
        #1 readStrobe = 1'b1;
        regAddr = 8'h3A;
        @(posedge mclk);
        #1 regAddr = 8'h4D;
        cmp("b2b", 16'h0001, readData_reg);
        @(posedge mclk);
        #1 readStrobe = 1'b0;
        cmp("b2b", 16'h0A00, readData_reg);
        // Mid-run reset with a fault level present; first read right at release
        setLv(36'h200000000);
        @(posedge mclk);
        #1 rst = 1'b1;
        @(posedge mclk);
        #1 rst = 1'b0;
        readStrobe = 1'b1;
        regAddr = 8'h4D;
        @(posedge mclk);
        #1 readStrobe = 1'b0;
        cmp("rstcode", 16'h0000, readData_reg);
        repeat (3) @(posedge mclk);
        rdChk(8'h4D, 16'h0700);
        conclude;
    end
endmodule
